// *** dv/soft_pin_section2_config_tb_top.sv ***
// Self-checking testbench for the soft-pin section 2 register block.
`timescale 1ns/1ps
module soft_pin_section2_config_tb_top;
   import spin2_pkg::*;
   localparam int LC = 4;
   logic i_clk, i_nrst, awvalid, wvalid, bready, arvalid, rready, pin, ce;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, o_rdata;
   logic [3:0] wstrb;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_act, o_pm, o_loading, o_core;
   logic [1:0] o_bresp, o_rresp, o_tol;
   logic [4:0] o_adiv, o_bdiv, o_c0, o_c1;
   logic [6:0] o_bw;
   logic [2:0] o_idx;
   int fails = 0;
   int n_checks = 0;
   int load_cnt = 0;
   int core_cnt = 0;
   int idx_bad = 0;

   soft_pin_section2_config #(.ADDR_W(16), .LOAD_CYCLES(LC)) i_soft_pin_section2_config (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready),
      .i_hw_config_select_pin(pin), .o_settings_active(o_act),
      .o_ref_input_a_div(o_adiv), .o_ref_input_b_div(o_bdiv), .o_ch0_div(o_c0), .o_ch1_div(o_c1),
      .o_high_pm_filter(o_pm), .o_digital_loop_bw_hz(o_bw), .o_ref_tol_code(o_tol),
      .o_rom_loading(o_loading), .o_rom_word_idx(o_idx), .o_core_reset(o_core));

   initial
   begin
      i_clk = 1'h0;
      forever #50 i_clk = ~i_clk;
   end

   always @(posedge i_clk)
   begin
      if (o_loading === 1'h1)
      begin
         if (o_idx !== 3'(load_cnt))
            idx_bad++;
         load_cnt++;
      end
      if (o_core === 1'h1)
         core_cnt++;
   end

   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge i_clk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge i_clk);
         if (awvalid && o_awready === 1'h1)
         begin
            aw_ok = 1'h1;
            awvalid <= 1'h0;
         end
         if (wvalid && o_wready === 1'h1)
         begin
            w_ok = 1'h1;
            wvalid <= 1'h0;
         end
      end
      while (o_bvalid !== 1'h1)
         @(posedge i_clk);
      r = o_bresp;
      bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ok;
      ok = 1'h0;
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!ok)
      begin
         @(posedge i_clk);
         if (arvalid && o_arready === 1'h1)
            arvalid <= 1'h0;
         ok = (o_rvalid === 1'h1);
      end
      d = o_rdata;
      r = o_rresp;
      rready <= 1'h0;
   endtask

   task automatic wr_ok(input logic [15:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk_resp("write response", RESP_OKAY, r);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_val("read data", exp, d);
      chk_resp("read response", RESP_OKAY, r);
   endtask

   function automatic logic [4:0] div_exp(input logic [1:0] c);
      return (c == 2'h0) ? 5'h01 : (c == 2'h1) ? 5'h04 : (c == 2'h2) ? 5'h08 : 5'h10;
   endfunction

   function automatic logic [6:0] bw_exp(input logic [1:0] c);
      return (c == 2'h0) ? 7'h32 : (c == 2'h1) ? 7'h01 : (c == 2'h2) ? 7'h0A : 7'h64;
   endfunction

   task automatic chk_out(input logic act, input logic [4:0] a, input logic [4:0] b, input logic [4:0] c0,
                          input logic [4:0] c1, input logic pm, input logic [6:0] bw, input logic [1:0] tol);
      repeat (3) @(posedge i_clk);
      chk_val("active", {31'h0, act}, {31'h0, o_act});
      chk_val("ref a div", {27'h0, a}, {27'h0, o_adiv});
      chk_val("ref b div", {27'h0, b}, {27'h0, o_bdiv});
      chk_val("ch0 div", {27'h0, c0}, {27'h0, o_c0});
      chk_val("ch1 div", {27'h0, c1}, {27'h0, o_c1});
      chk_val("phase margin", {31'h0, pm}, {31'h0, o_pm});
      chk_val("loop bw", {25'h0, bw}, {25'h0, o_bw});
      chk_val("tolerance", {30'h0, tol}, {30'h0, o_tol});
   endtask

   task automatic t_reset();
      for (int i = 0; i < 6; i++)
         rd_chk(16'h300C + 16'(4 * i), 32'h0);
      chk_out(1'h0, 5'h01, 5'h01, 5'h01, 5'h01, 1'h0, 7'h32, 2'h0);
      chk_val("loading", 32'h0, {31'h0, o_loading});
   endtask

   task automatic t_enable();
      wr_ok(16'h3010, 32'h0F);
      wr_ok(16'h3014, 32'h0F);
      wr_ok(16'h3018, 32'h1F);
      chk_out(1'h0, 5'h01, 5'h01, 5'h01, 5'h01, 1'h0, 7'h32, 2'h0);
      wr_ok(16'h300C, 32'h01);
      chk_out(1'h1, 5'h10, 5'h10, 5'h10, 5'h10, 1'h1, 7'h64, 2'h3);
      @(posedge i_clk);
      pin <= 1'h1;
      chk_out(1'h0, 5'h01, 5'h01, 5'h01, 5'h01, 1'h0, 7'h32, 2'h0);
      @(posedge i_clk);
      pin <= 1'h0;
      chk_out(1'h1, 5'h10, 5'h10, 5'h10, 5'h10, 1'h1, 7'h64, 2'h3);
   endtask

   task automatic t_codes();
      logic [1:0] c, d;
      for (int i = 0; i < 4; i++)
      begin
         c = 2'(i);
         d = 2'(3 - i);
         wr_ok(16'h3010, {28'h0, d, c});
         wr_ok(16'h3014, {28'h0, c, d});
         wr_ok(16'h3018, {27'h0, c[0], d, c});
         chk_out(1'h1, div_exp(c), div_exp(d), div_exp(d), div_exp(c), c[0], bw_exp(d), c);
      end
   endtask

   task automatic t_reserved();
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] mask [4] = '{8'h01, 8'h0F, 8'h0F, 8'h1F};
      for (int i = 0; i < 4; i++)
      begin
         wr_ok(16'h300C + 16'(4 * i), 32'hFFFF_FFFF);
         rd_chk(16'h300C + 16'(4 * i), {24'h0, mask[i]});
      end
      axi_wr(16'h3024, 32'h01, r);
      chk_resp("unmapped write", RESP_SLVERR, r);
      axi_rd(16'h3008, d, r);
      chk_resp("unmapped read", RESP_SLVERR, r);
      chk_val("unmapped data", 32'h0, d);
   endtask

   task automatic t_trigger(input logic [15:0] a, input int pulses);
      @(negedge i_clk);
      load_cnt = 0;
      core_cnt = 0;
      idx_bad = 0;
      wr_ok(a, 32'hFF);
      rd_chk(a, 32'h01);
      for (int n = 0; n < 100 && o_loading !== 1'h0; n++)
         @(posedge i_clk);
      rd_chk(a, 32'h00);
      chk_val("load cycles", 32'(LC + 1), 32'(load_cnt));
      chk_val("core resets", 32'(pulses), 32'(core_cnt));
      chk_val("word index", 32'h0, 32'(idx_bad));
      rd_chk(16'h3018, 32'h1F);
      chk_out(1'h1, 5'h10, 5'h10, 5'h10, 5'h10, 1'h1, 7'h64, 2'h3);
   endtask

   // With the clock enable low the outputs must hold although the pin changes.
   task automatic t_freeze();
      @(posedge i_clk);
      ce <= 1'h0;
      pin <= 1'h1;
      chk_out(1'h1, 5'h10, 5'h10, 5'h10, 5'h10, 1'h1, 7'h64, 2'h3);
      @(posedge i_clk);
      ce <= 1'h1;
      chk_out(1'h0, 5'h01, 5'h01, 5'h01, 5'h01, 1'h0, 7'h32, 2'h0);
      @(posedge i_clk);
      pin <= 1'h0;
      chk_out(1'h1, 5'h10, 5'h10, 5'h10, 5'h10, 1'h1, 7'h64, 2'h3);
   endtask

   task automatic close_out();
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      i_nrst = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready, pin} = 6'h00;
      ce = 1'h1;
      awaddr = 16'h0;
      araddr = 16'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'h1;
      t_reset();
      t_enable();
      t_codes();
      t_reserved();
      t_trigger(16'h301C, 0);
      t_trigger(16'h3020, 1);
      t_freeze();
      close_out();
   end

   // The whole sequence needs well under a thousand cycles.
   initial
   begin
      repeat (5000) @(posedge i_clk);
      fails++;
      close_out();
   end
endmodule // soft_pin_section2_config_tb_top

// *** rtl/rom_load_if.sv ***
// Handshake between the register file and the ROM download sequencer.
`timescale 1ns/1ps
interface rom_load_if;
   logic start;
   logic busy;
   logic done;
   modport ctrl (output start, input busy, input done);
   modport seq (input start, output busy, output done);
endinterface

// *** rtl/rom_loader.sv ***
// Sequencer that runs one ROM download of soft-pin settings per start.
`timescale 1ns/1ps
module rom_loader
   import spin2_pkg::*;
#(
   parameter int LOAD_CYCLES = LOAD_CYCLES_DEF
)
(
   // Clock, reset and enable
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Request from the register file
   rom_load_if.seq lp,
   // ROM fetch position
   output logic [$clog2(LOAD_CYCLES+1)-1:0] o_word_idx
);
   localparam int CNT_W = $clog2(LOAD_CYCLES + 1);

   ld_state_t state_r;
   ld_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic last_w;

   assign last_w = (cnt_r == CNT_W'(LOAD_CYCLES - 1));
   assign lp.busy = (state_r != LD_IDLE);
   assign lp.done = (state_r == LD_DONE);
   assign o_word_idx = cnt_r;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         LD_IDLE:
         begin
            cnt_nxt = '0;
            if (lp.start)
            begin
               state_nxt = LD_RUN;
            end
         end
         LD_RUN:
         begin
            cnt_nxt = cnt_r + CNT_W'(1);
            if (last_w)
            begin
               state_nxt = LD_DONE;
            end
         end
         LD_DONE:
         begin
            state_nxt = LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_r <= LD_IDLE;
         cnt_r <= '0;
      end
      else if (i_ce)
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   run_length_a: assert property (@(posedge i_clk) disable iff (!i_nrst || !i_ce)
      (state_r == LD_DONE) |-> ($past(state_r) == LD_RUN && $past(cnt_r) == CNT_W'(LOAD_CYCLES - 1)))
      else $error("download ended after the wrong number of cycles");

endmodule // rom_loader

// *** rtl/soft_pin_section2_config.sv ***
// Soft-pin section 2 register file with AXI4-Lite access and ROM download triggers.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module soft_pin_section2_config
   import spin2_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int LOAD_CYCLES = LOAD_CYCLES_DEF
)
(
   // Clock, reset and enable
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // AXI4-Lite write channels
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read channels
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Hardware configuration select pin
   input wire logic i_hw_config_select_pin,
   // Effective settings
   output logic o_settings_active,
   output logic [4:0] o_ref_input_a_div,
   output logic [4:0] o_ref_input_b_div,
   output logic [4:0] o_ch0_div,
   output logic [4:0] o_ch1_div,
   output logic o_high_pm_filter,
   output logic [6:0] o_digital_loop_bw_hz,
   output logic [1:0] o_ref_tol_code,
   // ROM download and core reset
   output logic o_rom_loading,
   output logic [$clog2(LOAD_CYCLES+1)-1:0] o_rom_word_idx,
   output logic o_core_reset
);
   rom_load_if lp ();

   logic aw_r;
   logic w_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wbyte_r;
   logic wstrb0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] ena_r;
   logic [7:0] in_r;
   logic [7:0] out_r;
   logic [7:0] loop_r;
   logic xfer_r;
   logic sprst_r;
   logic xfer_nxt;
   logic sprst_nxt;
   logic own_x_r;
   logic own_s_r;
   logic active_nxt;

   // Write path decode.
   wire [13:0] wr_idx = awaddr_r[15:2];
   wire wr_go = aw_r && w_r && !bvalid_r;
   wire wr_hit = (wr_idx == IDX_ENABLE) || (wr_idx == IDX_IN_SCALE) || (wr_idx == IDX_OUT_SCALE) ||
                 (wr_idx == IDX_LOOP) || (wr_idx == IDX_XFER) || (wr_idx == IDX_SPRST);
   wire wr_en = wr_go && wstrb0_r && wr_hit;
   wire wr_ena = wr_en && (wr_idx == IDX_ENABLE);
   wire wr_in = wr_en && (wr_idx == IDX_IN_SCALE);
   wire wr_out = wr_en && (wr_idx == IDX_OUT_SCALE);
   wire wr_loop = wr_en && (wr_idx == IDX_LOOP);
   wire xfer_set = wr_en && (wr_idx == IDX_XFER) && wbyte_r[TRIG_BIT];
   wire sprst_set = wr_en && (wr_idx == IDX_SPRST) && wbyte_r[TRIG_BIT];

   // Read path decode.
   wire [13:0] rd_idx = i_araddr[15:2];
   wire rd_go = i_arvalid && !rvalid_r;
   wire rd_hit = (rd_idx == IDX_ENABLE) || (rd_idx == IDX_IN_SCALE) || (rd_idx == IDX_OUT_SCALE) ||
                 (rd_idx == IDX_LOOP) || (rd_idx == IDX_XFER) || (rd_idx == IDX_SPRST);
   wire [7:0] rd_byte = (rd_idx == IDX_ENABLE) ? ena_r :
                        (rd_idx == IDX_IN_SCALE) ? in_r :
                        (rd_idx == IDX_OUT_SCALE) ? out_r :
                        (rd_idx == IDX_LOOP) ? loop_r :
                        (rd_idx == IDX_XFER) ? {7'h00, xfer_r} :
                        (rd_idx == IDX_SPRST) ? {7'h00, sprst_r} : 8'h00;

   // A download is requested by either trigger while the sequencer is free.
   assign lp.start = (xfer_r || sprst_r) && !lp.busy;
   wire own_done_x = lp.done && own_x_r;
   wire own_done_s = lp.done && own_s_r;
   // A fresh write of 1 in the finishing cycle keeps the bit set.
   assign xfer_nxt = xfer_set || (xfer_r && !own_done_x);
   assign sprst_nxt = sprst_set || (sprst_r && !own_done_s);
   assign active_nxt = ena_r[ENA_BIT] && !i_hw_config_select_pin;

   // Readies stay low while the clock enable is low, so that no transfer is taken and then lost.
   assign o_awready = i_ce && !aw_r && !bvalid_r;
   assign o_wready = i_ce && !w_r && !bvalid_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_arready = i_ce && !rvalid_r;
   assign o_rvalid = rvalid_r;
   assign o_rresp = rresp_r;
   assign o_rdata = rdata_r;
   assign o_rom_loading = lp.busy;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aw_r <= 1'b0;
         w_r <= 1'b0;
         awaddr_r <= '0;
         wbyte_r <= 8'h00;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (i_awvalid && o_awready)
         begin
            aw_r <= 1'b1;
            awaddr_r <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_r <= 1'b1;
            wbyte_r <= i_wdata[7:0];
            wstrb0_r <= i_wstrb[0];
         end
         if (wr_go)
         begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_r && i_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         if (rd_go)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= {24'h000000, rd_byte};
         end
         else if (rvalid_r && i_rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Settings registers; only documented bits are stored.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ena_r <= RST_REG;
         in_r <= RST_REG;
         out_r <= RST_REG;
         loop_r <= RST_REG;
      end
      else if (i_ce)
      begin
         if (wr_ena)
            ena_r <= wbyte_r & ENA_MASK;
         if (wr_in)
            in_r <= wbyte_r & IN_MASK;
         if (wr_out)
            out_r <= wbyte_r & OUT_MASK;
         if (wr_loop)
            loop_r <= wbyte_r & LOOP_MASK;
      end
   end

   // Triggers, download ownership and the core reset pulse.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         xfer_r <= 1'b0;
         sprst_r <= 1'b0;
         own_x_r <= 1'b0;
         own_s_r <= 1'b0;
         o_core_reset <= 1'b0;
      end
      else if (i_ce)
      begin
         xfer_r <= xfer_nxt;
         sprst_r <= sprst_nxt;
         if (lp.start)
         begin
            own_x_r <= xfer_r;
            own_s_r <= sprst_r;
         end
         o_core_reset <= lp.start && sprst_r;
      end
   end

   // Effective settings fall back to defaults when the section is off.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_settings_active <= 1'b0;
         o_ref_input_a_div <= RST_DIV;
         o_ref_input_b_div <= RST_DIV;
         o_ch0_div <= RST_DIV;
         o_ch1_div <= RST_DIV;
         o_high_pm_filter <= 1'b0;
         o_digital_loop_bw_hz <= RST_BW_HZ;
         o_ref_tol_code <= 2'h0;
      end
      else if (i_ce)
      begin
         o_settings_active <= active_nxt;
         o_ref_input_b_div <= active_nxt ? scale_div(in_r[REF_INPUT_B_LSB +: 2]) : RST_DIV;
         o_ref_input_a_div <= active_nxt ? scale_div(in_r[REF_INPUT_A_LSB +: 2]) : RST_DIV;
         o_ch1_div <= active_nxt ? scale_div(out_r[CH1_LSB +: 2]) : RST_DIV;
         o_ch0_div <= active_nxt ? scale_div(out_r[CH0_LSB +: 2]) : RST_DIV;
         o_high_pm_filter <= active_nxt && loop_r[PM_BIT];
         o_digital_loop_bw_hz <= active_nxt ? bw_hz(loop_r[BW_LSB +: 2]) : RST_BW_HZ;
         o_ref_tol_code <= active_nxt ? loop_r[TOL_LSB +: 2] : 2'h0;
      end
   end

   rom_loader #(
      .LOAD_CYCLES(LOAD_CYCLES)
   ) i_rom_loader (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .lp(lp.seq),
      .o_word_idx(o_rom_word_idx)
   );

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst || !i_ce);

   active_gate_a: assert property ($past(i_ce) |-> $past(active_nxt, 1) == o_settings_active)
      else $error("active flag does not follow enable and pin");
   off_defaults_a: assert property (!o_settings_active |-> (o_ref_input_a_div == 5'h01 && o_ch1_div == 5'h01
      && o_digital_loop_bw_hz == 7'h32 && !o_high_pm_filter))
      else $error("settings leak while section is off");
   ref_input_b_scale_a: assert property (wr_in && active_nxt && wbyte_r[3:2] == 2'h3 ##1 active_nxt |=>
      o_ref_input_b_div == 5'h10)
      else $error("input B scale wrong");
   ref_input_a_scale_a: assert property (wr_in && active_nxt && wbyte_r[1:0] == 2'h2 ##1 active_nxt |=>
      o_ref_input_a_div == 5'h08)
      else $error("input A scale wrong");
   ch1_scale_a: assert property (wr_out && active_nxt && wbyte_r[3:2] == 2'h1 ##1 active_nxt |=>
      o_ch1_div == 5'h04)
      else $error("channel 1 scale wrong");
   ch0_scale_a: assert property (wr_out && active_nxt && wbyte_r[1:0] == 2'h3 ##1 active_nxt |=>
      o_ch0_div == 5'h10)
      else $error("channel 0 scale wrong");
   pm_select_a: assert property (wr_loop && active_nxt ##1 active_nxt |=> o_high_pm_filter == $past(wbyte_r[4], 2))
      else $error("phase margin select wrong");
   bw_select_a: assert property (wr_loop && active_nxt && wbyte_r[3:2] == 2'h1 ##1 active_nxt |=>
      o_digital_loop_bw_hz == 7'h01)
      else $error("loop bandwidth wrong");
   tol_select_a: assert property (wr_loop && active_nxt ##1 active_nxt |=> o_ref_tol_code == $past(wbyte_r[1:0], 2))
      else $error("tolerance code wrong");
   xfer_start_a: assert property ($rose(xfer_r) && !lp.busy |-> lp.start ##1 lp.busy)
      else $error("transfer did not start a download");
   xfer_clear_a: assert property (own_done_x && !xfer_set |=> !xfer_r)
      else $error("transfer bit did not clear");
   core_reset_a: assert property (lp.start && sprst_r |=> o_core_reset ##1 !o_core_reset)
      else $error("core reset pulse wrong");
   regs_kept_a: assert property (o_core_reset && !$past(wr_en) |-> $stable(in_r) && $stable(ena_r))
      else $error("register map changed by soft-pin reset");
   sprst_clear_a: assert property (own_done_s && !sprst_set |=> !sprst_r)
      else $error("soft-pin reset bit did not clear");
   reserved_zero_a: assert property (rvalid_r |-> o_rdata[31:5] == 27'h0)
      else $error("reserved bits read nonzero");

   xfer_run_c: cover property (xfer_set ##[1:40] own_done_x);
   sprst_run_c: cover property (sprst_set ##[1:40] own_done_s);
   active_c: cover property ($rose(o_settings_active));
   retrigger_c: cover property (lp.done && (xfer_set || sprst_set));

endmodule // soft_pin_section2_config

// *** rtl/spin2_pkg.sv ***
// Constants, register map and decode helpers for the soft-pin section 2 block.
package spin2_pkg;

   // Register indices; byte address on the bus is four times the index.
   localparam logic [13:0] IDX_ENABLE = 14'h0C03;
   localparam logic [13:0] IDX_IN_SCALE = 14'h0C04;
   localparam logic [13:0] IDX_OUT_SCALE = 14'h0C05;
   localparam logic [13:0] IDX_LOOP = 14'h0C06;
   localparam logic [13:0] IDX_XFER = 14'h0C07;
   localparam logic [13:0] IDX_SPRST = 14'h0C08;

   // Field positions.
   localparam int ENA_BIT = 0;
   localparam int REF_INPUT_A_LSB = 0;
   localparam int REF_INPUT_B_LSB = 2;
   localparam int CH0_LSB = 0;
   localparam int CH1_LSB = 2;
   localparam int TOL_LSB = 0;
   localparam int BW_LSB = 2;
   localparam int PM_BIT = 4;
   localparam int TRIG_BIT = 0;

   // Writable bits of each register; the rest read as zero.
   localparam logic [7:0] ENA_MASK = 8'h01;
   localparam logic [7:0] IN_MASK = 8'h0F;
   localparam logic [7:0] OUT_MASK = 8'h0F;
   localparam logic [7:0] LOOP_MASK = 8'h1F;

   // Values after reset.
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [4:0] RST_DIV = 5'h01;
   localparam logic [6:0] RST_BW_HZ = 7'h32;

   // Cycles that one ROM download of soft-pin settings takes.
   localparam int LOAD_CYCLES_DEF = 16;

   // Bus response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {LD_IDLE, LD_RUN, LD_DONE} ld_state_t;

   // Frequency scale code to divide ratio.
   function automatic logic [4:0] scale_div(input logic [1:0] code);
      unique case (code)
         2'h0: scale_div = 5'h01;
         2'h1: scale_div = 5'h04;
         2'h2: scale_div = 5'h08;
         2'h3: scale_div = 5'h10;
      endcase
   endfunction

   // Loop bandwidth code to hertz.
   function automatic logic [6:0] bw_hz(input logic [1:0] code);
      unique case (code)
         2'h0: bw_hz = 7'h32;
         2'h1: bw_hz = 7'h01;
         2'h2: bw_hz = 7'h0A;
         2'h3: bw_hz = 7'h64;
      endcase
   endfunction

endpackage
